// ---- inc/fbd_map.svh ----
// Timing constants of the full-bridge drive sequencer.
// Assumes a 10 MHz functional clock; every count is derived from the times below.
`ifndef FBD_MAP_SVH
`define FBD_MAP_SVH

`define FBD_CLK_HZ        10000000
`define FBD_OSC_HZ        250000
`define FBD_DEAD_NS       180
`define FBD_WAIT_NS       500
`define FBD_FALLBACK_PER  6
`define FBD_THERM_PER     256

// Least times round up, longest times round down
`define FBD_OSC_CYC       (`FBD_CLK_HZ / `FBD_OSC_HZ)
`define FBD_HALF_CYC      (`FBD_OSC_CYC / 2)
`define FBD_DEAD_CYC      ((`FBD_DEAD_NS * (`FBD_CLK_HZ / 1000000) + 999) / 1000)
`define FBD_WAIT_CYC      ((`FBD_WAIT_NS * (`FBD_CLK_HZ / 1000000)) / 1000)
`define FBD_FALLBACK_CYC  (`FBD_FALLBACK_PER * `FBD_OSC_CYC)
`define FBD_THERM_CYC     (`FBD_THERM_PER * `FBD_OSC_CYC)

`define FBD_HC_W          5
`define FBD_DC_W          3
`define FBD_SC_W          8
`define FBD_TC_W          14

`define FBD_SYNC_RST      1'b1

`endif

// ---- inc/fbd_pkg.sv ----
// Types of the full-bridge drive sequencer.
// Widths come from fbd_map.svh, which must be on the include path.
`include "fbd_map.svh"

package fbd_pkg;

	typedef enum logic [1:0] {
		FBD_IDLE,
		FBD_DEAD,
		FBD_ON,
		FBD_THERM
	} fbd_state_t;

	typedef struct packed {
		logic gate_one;
		logic gate_two;
	} fbd_drive_t;

	typedef struct packed {
		logic [2:0]            sync_sh;
		logic [1:0]            en_sh;
		logic [1:0]            dda_sh;
		logic [1:0]            ddb_sh;
		logic [1:0]            ot_sh;
		logic [1:0]            tok_sh;
		fbd_state_t            state;
		logic                  phase;
		logic                  ext_mode;
		logic [`FBD_HC_W-1:0]  hc;
		logic [`FBD_DC_W-1:0]  dc;
		logic [`FBD_SC_W-1:0]  sc;
		logic [`FBD_TC_W-1:0]  tc;
		fbd_drive_t            drive;
		logic                  standby;
	} fbd_regs_t;

endpackage

// ---- design/fbd_seq.sv ----
// Full-bridge drive sequencer: clock source choice, two-phase gate drive, dead time, shutdown.
// Assumes pins arrive asynchronous to mclk_i; the analog stage owns the switches themselves.
//
// Notes on behaviour
// - Sync pin high: internal 250 kHz, fixed dead
// - Sync pin low: internal 250 kHz, adaptive dead
// - External sync clock divided by two
// - Both phases equal duration, symmetric
// - Enable low stops switching; high runs
// - Enable low: standby, all switches off
// - Fixed dead time nominal 180 ns
// - Adaptive: turn on after drain drop
// - Adaptive wait at most 500 ns
// - Thermal off at least 256 periods
// - Six quiet periods: back to internal
// - No drain drop: turn on at limit
// - Restart needs cool and elapsed wait
// - Dead time holds both gates low
`timescale 1ns/1ps
`include "fbd_map.svh"

module fbd_seq #(
	parameter int THERM_OFF_CYC = `FBD_THERM_CYC
) (
	input  wire logic mclk_i,
	input  wire logic rst_n_i,
	input  wire logic sync_clk_i,
	input  wire logic enable_i,
	input  wire logic drain_drop_a_i,
	input  wire logic drain_drop_b_i,
	input  wire logic over_temp_i,
	input  wire logic temp_ok_i,
	output logic      gate_phase_one_o,
	output logic      gate_phase_two_o,
	output logic      standby_o,
	output logic      ext_clk_mode_o,
	output logic      adaptive_mode_o,
	output logic      thermal_off_o
);

	localparam logic [`FBD_HC_W-1:0] HALF_LAST  = `FBD_HC_W'(`FBD_HALF_CYC - 1);
	localparam logic [`FBD_DC_W-1:0] DEAD_LAST  = `FBD_DC_W'(`FBD_DEAD_CYC - 1);
	localparam logic [`FBD_DC_W-1:0] WAIT_LAST  = `FBD_DC_W'(`FBD_WAIT_CYC - 1);
	localparam logic [`FBD_SC_W-1:0] FALL_LAST  = `FBD_SC_W'(`FBD_FALLBACK_CYC - 1);
	localparam logic [`FBD_TC_W-1:0] THERM_LAST = `FBD_TC_W'(THERM_OFF_CYC - 1);

	fbd_pkg::fbd_regs_t st_ff;
	fbd_pkg::fbd_regs_t nxt_st;

	logic sync_lvl;
	logic sync_rise;
	logic sync_edge;
	logic adaptive;
	logic tick;
	logic drop_seen;
	logic dead_done;

	// Only the second and third sync stages are looked at
	assign sync_lvl  = st_ff.sync_sh[1];
	assign sync_rise = st_ff.sync_sh[1] & ~st_ff.sync_sh[2];
	assign sync_edge = st_ff.sync_sh[1] ^ st_ff.sync_sh[2];
	assign adaptive  = ~st_ff.ext_mode & ~sync_lvl;
	// External mode: each rising edge flips the phase, so drive runs at half rate
	assign tick      = st_ff.ext_mode ? sync_rise : (st_ff.hc == HALF_LAST);
	// Phase 0 turns on gate one, which waits for node a to fall
	assign drop_seen = st_ff.phase ? st_ff.ddb_sh[1] : st_ff.dda_sh[1];
	// At or past the limit, so a mode change in mid-wait cannot skip the end point
	assign dead_done = adaptive ? (drop_seen || st_ff.dc >= WAIT_LAST)
	                            : (st_ff.dc >= DEAD_LAST);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.sync_sh = {st_ff.sync_sh[1:0], sync_clk_i};
		nxt_st.en_sh   = {st_ff.en_sh[0], enable_i};
		nxt_st.dda_sh  = {st_ff.dda_sh[0], drain_drop_a_i};
		nxt_st.ddb_sh  = {st_ff.ddb_sh[0], drain_drop_b_i};
		nxt_st.ot_sh   = {st_ff.ot_sh[0], over_temp_i};
		nxt_st.tok_sh  = {st_ff.tok_sh[0], temp_ok_i};

		// Source detection: any edge restarts the quiet count
		if (sync_edge) begin
			nxt_st.sc = '0;
			if (sync_rise) begin
				nxt_st.ext_mode = 1'b1;
			end
		end else if (st_ff.sc == FALL_LAST) begin
			nxt_st.ext_mode = 1'b0;
		end else begin
			nxt_st.sc = st_ff.sc + 1'b1;
		end

		// Internal oscillator, held at zero while synchronised externally
		if (st_ff.ext_mode || st_ff.hc == HALF_LAST) begin
			nxt_st.hc = '0;
		end else begin
			nxt_st.hc = st_ff.hc + 1'b1;
		end

		if (tick) begin
			nxt_st.phase = ~st_ff.phase;
		end
		nxt_st.standby = ~st_ff.en_sh[1];

		if (st_ff.ot_sh[1]) begin
			// Trip restarts the cooldown; hotter again means longer off time
			nxt_st.state = fbd_pkg::FBD_THERM;
			nxt_st.tc    = '0;
			nxt_st.drive = '0;
		end else if (st_ff.state == fbd_pkg::FBD_THERM) begin
			nxt_st.drive = '0;
			if (st_ff.tc != THERM_LAST) begin
				nxt_st.tc = st_ff.tc + 1'b1;
			end else if (st_ff.tok_sh[1]) begin
				nxt_st.state = fbd_pkg::FBD_IDLE;
			end
		end else if (!st_ff.en_sh[1]) begin
			nxt_st.state = fbd_pkg::FBD_IDLE;
			nxt_st.drive = '0;
		end else if (tick) begin
			nxt_st.state = fbd_pkg::FBD_DEAD;
			nxt_st.dc    = '0;
			nxt_st.drive = '0;
		end else begin
			case (st_ff.state)
				fbd_pkg::FBD_DEAD: begin
					if (dead_done) begin
						nxt_st.state          = fbd_pkg::FBD_ON;
						nxt_st.drive.gate_one = ~st_ff.phase;
						nxt_st.drive.gate_two = st_ff.phase;
					end else begin
						nxt_st.dc = st_ff.dc + 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_ff          <= '0;
			st_ff.sync_sh  <= {3{`FBD_SYNC_RST}};
			st_ff.state    <= fbd_pkg::FBD_IDLE;
			st_ff.standby  <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign gate_phase_one_o = st_ff.drive.gate_one;
	assign gate_phase_two_o = st_ff.drive.gate_two;
	assign standby_o        = st_ff.standby;
	assign ext_clk_mode_o   = st_ff.ext_mode;
	assign adaptive_mode_o  = adaptive;
	assign thermal_off_o    = (st_ff.state == fbd_pkg::FBD_THERM);

	// Checks
	localparam int WAIT_N = `FBD_WAIT_CYC;
	localparam int DEAD_N = `FBD_DEAD_CYC;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	a_gates_exclusive: assert property (
		!(gate_phase_one_o && gate_phase_two_o)
	) else $error("both gates high");

	a_enable_standby: assert property (
		!st_ff.en_sh[1] |=> !gate_phase_one_o && !gate_phase_two_o && standby_o
	) else $error("switching while disabled");

	a_fixed_dead: assert property (
		($rose(gate_phase_one_o) || $rose(gate_phase_two_o)) && !$past(adaptive)
		|-> $past(st_ff.drive == '0, DEAD_N)
	) else $error("fixed dead time too short");

	a_adapt_limit: assert property (
		$rose(st_ff.state == fbd_pkg::FBD_DEAD) && adaptive
		|-> ##[1:WAIT_N] (st_ff.state != fbd_pkg::FBD_DEAD || $past(tick) || !st_ff.en_sh[1])
	) else $error("adaptive wait exceeded");

	a_adapt_drop: assert property (
		st_ff.state == fbd_pkg::FBD_DEAD && adaptive && drop_seen && !tick
		&& st_ff.en_sh[1] && !st_ff.ot_sh[1]
		|=> st_ff.state == fbd_pkg::FBD_ON
	) else $error("drain drop ignored");

	a_therm_hold: assert property (
		$fell(thermal_off_o) |-> $past(st_ff.tc) == THERM_LAST && $past(st_ff.tok_sh[1])
	) else $error("thermal exit too early");

	a_ext_divide: assert property (
		st_ff.ext_mode && sync_rise |=> st_ff.phase != $past(st_ff.phase)
	) else $error("external edge did not flip phase");

	a_int_period: assert property (
		!st_ff.ext_mode && st_ff.hc == HALF_LAST && !sync_rise
		|=> st_ff.hc == '0 && st_ff.phase != $past(st_ff.phase)
	) else $error("internal half period wrong");

	a_fallback: assert property (
		st_ff.sc == FALL_LAST && !sync_edge |=> !ext_clk_mode_o
	) else $error("no fallback to internal clock");

	a_ext_entry: assert property (
		sync_rise |=> ext_clk_mode_o
	) else $error("sync edge did not select external clock");

	a_therm_gates: assert property (
		thermal_off_o |-> !gate_phase_one_o && !gate_phase_two_o
	) else $error("switching during thermal shutdown");

	a_dead_low: assert property (
		st_ff.state == fbd_pkg::FBD_DEAD |-> !gate_phase_one_o && !gate_phase_two_o
	) else $error("gate high during dead time");

	c_ext_run: cover property (ext_clk_mode_o ##1 $rose(gate_phase_two_o));
	c_adapt_drop: cover property (adaptive && drop_seen && st_ff.state == fbd_pkg::FBD_DEAD);
	c_therm_exit: cover property ($fell(thermal_off_o));
	c_fixed_run: cover property (!adaptive && $rose(gate_phase_one_o));
	c_ext_fallback: cover property ($fell(ext_clk_mode_o));

endmodule

// ---- dv/fbd_bridge_model.sv ----
// Power stage model: drain-drop sense of both switch nodes.
// Assumes gate levels from the sequencer on the same clock.
`timescale 1ns/1ps
module fbd_bridge_model (
	input  wire logic       mclk_i,
	input  wire logic       gate_one_i,
	input  wire logic       gate_two_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       mute_i,
	output logic            drop_a_o,
	output logic            drop_b_o
);
	int   off_ff;
	logic two_last_ff = 1'b0;
	logic idle;
	always_ff @(posedge mclk_i) begin
		off_ff <= (gate_one_i | gate_two_i) ? 0 : off_ff + 1;
		if (gate_one_i | gate_two_i)
			two_last_ff <= gate_two_i;
	end
	// A node only swings once the opposite pair let go; mute models a stuck sense
	assign idle = !mute_i && !gate_one_i && !gate_two_i && off_ff >= int'(delay_i);
	assign drop_a_o = idle && two_last_ff;
	assign drop_b_o = idle && !two_last_ff;
endmodule

// ---- dv/fbd_seq_bench.sv ----
// Self-checking bench: fixed, adaptive and external timing, enable, thermal.
// Assumes fbd_map.svh on the include path and the bridge model compiled first.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin errors++; \
	$display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module fbd_seq_bench;
	localparam int THERM = 64;
	localparam int FALL  = 6 * 40;
	logic       mclk_i      = 1'b0;
	logic       rst_n_i     = 1'b0;
	logic       sync_clk_i  = 1'b1;
	logic       enable_i    = 1'b1;
	logic       over_temp_i = 1'b0;
	logic       temp_ok_i   = 1'b1;
	logic       mute        = 1'b0;
	logic [3:0] dly         = 4'h0;
	logic       g1, g2, g1p, g2p, drop_a, drop_b, standby, ext_md, adapt, t_off;
	int         errors, n_compared, cyc, off_n, hi_n, dead, width, n_rise, h, t0;

	fbd_seq #(.THERM_OFF_CYC(THERM)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
		.sync_clk_i(sync_clk_i), .enable_i(enable_i), .drain_drop_a_i(drop_a),
		.drain_drop_b_i(drop_b), .over_temp_i(over_temp_i), .temp_ok_i(temp_ok_i),
		.gate_phase_one_o(g1), .gate_phase_two_o(g2), .standby_o(standby),
		.ext_clk_mode_o(ext_md), .adaptive_mode_o(adapt), .thermal_off_o(t_off));
	fbd_bridge_model stage (.mclk_i(mclk_i), .gate_one_i(g1), .gate_two_i(g2),
		.delay_i(dly), .mute_i(mute), .drop_a_o(drop_a), .drop_b_o(drop_b));

	function automatic int on_width(input int period);
		return period / 2 - 2;
	endfunction

	task automatic results();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	// Waits for n gate turn-ons; the cycle ceiling cuts a hang
	task automatic rises(input int n);
		int t;
		t = n_rise;
		wait (n_rise >= t + n);
	endtask

	task automatic therm(input logic ok);
		int n;
		temp_ok_i = ok;
		over_temp_i = 1'b1;
		step($urandom_range(3, 9));
		`CHK("trip", 1'b1, t_off)
		over_temp_i = 1'b0;
		n = 0;
		while (t_off === 1'b1) begin
			step(1);
			n++;
			if (n == 2 * THERM)
				temp_ok_i = 1'b1;
		end
		`CHK("cool_min", 1'b1, n >= (ok ? THERM : 2 * THERM))
		`CHK("cool_max", 1'b1, n <= (ok ? THERM : 2 * THERM) + 8)
		rises(1);
	endtask

	initial begin
		forever #50 mclk_i = ~mclk_i;
	end

	always @(negedge mclk_i) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			results();
		end
		if (rst_n_i) begin
			`CHK("overlap", 1'b0, g1 & g2)
			if ((t_off | standby) === 1'b1)
				`CHK("gates_off", 2'b00, {g1, g2})
			if (g1 === 1'b0 && g2 === 1'b0)
				off_n++;
			if ((g1 & !g1p) | (g2 & !g2p)) begin
				dead = off_n;
				n_rise++;
			end
			if (g1 | g2) begin
				off_n = 0;
				hi_n++;
			end else if (g1p | g2p) begin
				width = hi_n;
				hi_n = 0;
			end
		end
		g1p = g1;
		g2p = g2;
	end

	initial begin
		void'($urandom(32'h10f6b987));
		step(12);
		rst_n_i = 1'b1;
		rises(3);
		`CHK("fix_mode", 2'b00, {ext_md, adapt})
		`CHK("fix_dead", 2, dead)
		t0 = cyc;
		rises(2);
		`CHK("int_period", 40, cyc - t0)
		`CHK("fix_width", on_width(40), width)
		sync_clk_i = 1'b0;
		step(4);
		`CHK("adapt_mode", 1'b1, adapt)
		for (int i = 0; i < 6; i++) begin
			dly = 4'($urandom_range(0, 1));
			rises(2);
			`CHK("adapt_fast", 1'b1, dead < 5 && dead >= 1)
		end
		mute = 1'b1;
		rises(2);
		`CHK("adapt_limit", 5, dead)
		mute = 1'b0;
		h = $urandom_range(5, 12);
		for (int i = 0; i < 12; i++) begin
			sync_clk_i = ~sync_clk_i;
			step(h);
		end
		`CHK("ext_mode", 1'b1, ext_md)
		`CHK("ext_width", on_width(4 * h), width)
		`CHK("ext_dead", 2, dead)
		step(FALL - 20 - h);
		`CHK("ext_hold", 1'b1, ext_md)
		step(30);
		`CHK("fallback", 2'b01, {ext_md, adapt})
		// Pin stays low so internal ticks keep coming while disabled
		enable_i = 1'b0;
		step(4);
		`CHK("standby", 1'b1, standby)
		h = n_rise;
		step($urandom_range(30, 90));
		`CHK("no_switch", h, n_rise)
		sync_clk_i = 1'b1;
		enable_i = 1'b1;
		step(4);
		`CHK("wake", 1'b0, standby)
		rises(2);
		therm(1'b1);
		therm(1'b0);
		results();
	end
endmodule
